// >>> logic/tws_device.sv
// Two-wire register slave with a 256-entry byte register space and tuner port.
// Assumes link_clk oversamples the serial clock at least eight times per bit.
//
// Overview of operation
// [R1] Latch strap pins as address at reset release
// [R2] Reset held low 50 ms after power-up
// [R3] Address lsb high reads, low writes
// [R4] First written byte loads 8-bit register pointer
// [R5] Pointer increments after every data byte
// [R6] Master avoids altering reserved register locations
// [R7] Stop after matching address clears pointer
// [R8] Unmatched address ignored until valid address
// [R9] Start or repeated start keeps pointer
// [R10] Write after combined read continues at pointer
// [R11] Master ends every message with stop
// [R12] Read after stop returns register zero first
// [R13] Bytes travel most significant bit first
// [R14] Port configuration turns port into tuner bus
// [R15] Scan control bit 3 selects master mode
// [R16] Serial clock at most 400 kHz
// [R17] Slave acks address and writes; master acks reads
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module tws_device #(
    parameter logic [1:0] ADDR_HIGH = 2'b00
) (
    input wire logic link_clk,
    input wire logic [4:0] address_strap_pins,
    input wire logic tuner_clk_drive_low,
    input wire logic tuner_data_drive_low,
    output logic tuner_data_in,
    output logic tuner_master_mode,
    output logic tuner_bus_enable,
    output logic [7:0] scan_control,
    output logic [7:0] port_configuration,
    input wire logic port_bit_zero_in,
    output logic port_bit_zero_out,
    output logic port_bit_zero_oe,
    input wire logic port_bit_one_in,
    output logic port_bit_one_out,
    output logic port_bit_one_oe,
    tws_link_if.device link
);
    import tws_pkg::*;

    typedef enum logic [6:0] {
        D_IDLE = 7'b000_0001,
        D_ADDR = 7'b000_0010,
        D_AACK = 7'b000_0100,
        D_RX = 7'b000_1000,
        D_RACK = 7'b001_0000,
        D_TX = 7'b010_0000,
        D_TACK = 7'b100_0000
    } tws_dstate_t;

    logic scl_m, scl_s, scl_p;
    logic sda_m, sda_s, sda_p;
    logic rstn_m, rstn_s, rstn_p;
    logic [4:0] strap_m, strap_s;
    logic p1_m, p1_s;
    logic rst;
    logic rise, fall, start_seen, stop_seen;

    tws_dstate_t state_q, state_d;
    logic [7:0] sh_q, sh_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] ptr_q, ptr_d;
    logic [4:0] addr_q, addr_d;
    logic matched_q, matched_d;
    logic rw_q, rw_d;
    logic first_q, first_d;
    logic combined_q, combined_d;
    logic acked_q, acked_d;
    logic drive_q, drive_d;
    logic clk_oe_q, clk_oe_d;
    logic dat_oe_q, dat_oe_d;
    logic wr_en;
    logic [7:0] mem [REG_COUNT];
    logic [7:0] rd_byte;

    // Pin synchronisers; logic reads the second stage, plus a third stage for clock, data and reset edges
    always_ff @(posedge link_clk) begin
        scl_m <= link.scl_line;
        scl_s <= scl_m;
        sda_m <= link.sda_line;
        sda_s <= sda_m;
        rstn_m <= link.device_reset_n;
        rstn_s <= rstn_m;
        strap_m <= address_strap_pins;
        strap_s <= strap_m;
        p1_m <= port_bit_one_in;
        p1_s <= p1_m;
        scl_p <= scl_s;
        sda_p <= sda_s;
        rstn_p <= rstn_s;
    end

    assign rst = !rstn_s;
    assign rise = scl_s && !scl_p;
    assign fall = !scl_s && scl_p;
    assign start_seen = scl_s && scl_p && sda_p && !sda_s;
    assign stop_seen = scl_s && scl_p && !sda_p && sda_s;
    assign rd_byte = mem[ptr_q];

    always_comb begin
        state_d = state_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        ptr_d = ptr_q;
        addr_d = addr_q;
        matched_d = matched_q;
        rw_d = rw_q;
        first_d = first_q;
        combined_d = combined_q;
        acked_d = acked_q;
        drive_d = drive_q;
        wr_en = 1'b0;
        if (rstn_s && !rstn_p) begin
            addr_d = strap_s; // [R1]
        end
        if (start_seen) begin
            state_d = D_ADDR; // [R9]
            cnt_d = 4'h0;
            drive_d = 1'b0;
        end else if (stop_seen) begin
            if (matched_q) begin
                ptr_d = POINTER_RESET; // [R7] [R12]
            end
            matched_d = 1'b0;
            combined_d = 1'b0;
            drive_d = 1'b0;
            state_d = D_IDLE;
        end else begin
            unique case (state_q)
                D_IDLE: begin
                end
                D_ADDR: begin
                    if (rise) begin
                        sh_d = {sh_q[6:0], sda_s}; // [R13]
                        cnt_d = cnt_q + 1'b1;
                    end else if (fall && cnt_q == BIT_COUNT_BYTE) begin
                        if (sh_q[7:1] == {ADDR_HIGH, addr_q}) begin
                            matched_d = 1'b1;
                            rw_d = sh_q[0]; // [R3]
                            first_d = !sh_q[0] && !combined_q; // [R10]
                            combined_d = combined_q || sh_q[0];
                            drive_d = 1'b1; // [R17]
                            state_d = D_AACK;
                        end else begin
                            state_d = D_IDLE; // [R8]
                        end
                    end
                end
                D_AACK: begin
                    if (fall) begin
                        cnt_d = 4'h0;
                        if (rw_q) begin
                            sh_d = rd_byte;
                            drive_d = !rd_byte[7];
                            state_d = D_TX; // [R3]
                        end else begin
                            drive_d = 1'b0;
                            state_d = D_RX;
                        end
                    end
                end
                D_RX: begin
                    if (rise) begin
                        sh_d = {sh_q[6:0], sda_s}; // [R13]
                        cnt_d = cnt_q + 1'b1;
                    end else if (fall && cnt_q == BIT_COUNT_BYTE) begin
                        drive_d = 1'b1; // [R17]
                        state_d = D_RACK;
                        if (first_q) begin
                            ptr_d = sh_q; // [R4]
                            first_d = 1'b0;
                        end else begin
                            wr_en = 1'b1;
                            ptr_d = ptr_q + 1'b1; // [R5]
                        end
                    end
                end
                D_RACK: begin
                    if (fall) begin
                        drive_d = 1'b0;
                        cnt_d = 4'h0;
                        state_d = D_RX;
                    end
                end
                D_TX: begin
                    if (rise) begin
                        cnt_d = cnt_q + 1'b1;
                    end else if (fall) begin
                        if (cnt_q == BIT_COUNT_BYTE) begin
                            drive_d = 1'b0;
                            ptr_d = ptr_q + 1'b1; // [R5]
                            state_d = D_TACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            drive_d = !sh_q[6]; // [R13]
                        end
                    end
                end
                D_TACK: begin
                    if (rise) begin
                        acked_d = !sda_s;
                    end else if (fall) begin
                        if (acked_q) begin
                            sh_d = rd_byte;
                            drive_d = !rd_byte[7];
                            cnt_d = 4'h0;
                            state_d = D_TX;
                        end else begin
                            drive_d = 1'b0; // [R17]
                            state_d = D_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Tuner bus drive onto the port pins when the port is enabled as tuner bus and in master control mode
    always_comb begin
        clk_oe_d = tuner_bus_enable && tuner_master_mode && tuner_clk_drive_low; // [R14] [R15]
        dat_oe_d = tuner_bus_enable && tuner_master_mode && tuner_data_drive_low; // [R14]
    end

    always_ff @(posedge link_clk) begin
        if (rst) begin
            state_q <= D_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            ptr_q <= POINTER_RESET;
            addr_q <= 5'h00;
            matched_q <= 1'b0;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            combined_q <= 1'b0;
            acked_q <= 1'b0;
            drive_q <= 1'b0;
            clk_oe_q <= 1'b0;
            dat_oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            ptr_q <= ptr_d;
            addr_q <= addr_d;
            matched_q <= matched_d;
            rw_q <= rw_d;
            first_q <= first_d;
            combined_q <= combined_d;
            acked_q <= acked_d;
            drive_q <= drive_d;
            clk_oe_q <= clk_oe_d;
            dat_oe_q <= dat_oe_d;
        end
    end

    // Register space; the write uses the pointer before its increment
    always_ff @(posedge link_clk) begin
        if (rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                mem[i] <= REG_RESET;
            end
        end else if (wr_en) begin
            mem[ptr_q] <= sh_q;
        end
    end

    assign scan_control = mem[SCAN_CONTROL_OFS];
    assign port_configuration = mem[PORT_CONFIG_OFS];
    assign tuner_master_mode = scan_control[MASTER_MODE_BIT]; // [R15]
    assign tuner_bus_enable = port_configuration[TUNER_BUS_EN_BIT]; // [R14]
    assign tuner_data_in = p1_s;
    assign port_bit_zero_out = 1'b0;
    assign port_bit_zero_oe = clk_oe_q;
    assign port_bit_one_out = 1'b0;
    assign port_bit_one_oe = dat_oe_q;
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = drive_q;
endmodule

// >>> logic/tws_host.sv
// Two-wire bus master with an APB command and status port.
// Assumes the slave's sampling clock is fast enough for the serial timing used.
`timescale 1ns/1ps
module tws_host #(
    parameter int RESET_HOLD = tws_pkg::RESET_HOLD_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    tws_link_if.host link
);
    import tws_pkg::*;

    typedef enum logic [9:0] {
        H_RST = 10'b00_0000_0001,
        H_IDLE = 10'b00_0000_0010,
        H_SA = 10'b00_0000_0100,
        H_SB = 10'b00_0000_1000,
        H_SC = 10'b00_0001_0000,
        H_BLO = 10'b00_0010_0000,
        H_BHI = 10'b00_0100_0000,
        H_PA = 10'b00_1000_0000,
        H_PB = 10'b01_0000_0000,
        H_PC = 10'b10_0000_0000
    } tws_hstate_t;

    localparam logic [TIMER_W-1:0] LOW_T = TIMER_W'(SCL_LOW_CYC - 1);
    localparam logic [TIMER_W-1:0] HIGH_T = TIMER_W'(SCL_HIGH_CYC - 1);
    localparam logic [TIMER_W-1:0] HALF_T = TIMER_W'(SCL_LOW_CYC / 2);

    tws_hstate_t state_q, state_d;
    logic [TIMER_W-1:0] timer_q, timer_d;
    logic [31:0] rcnt_q, rcnt_d;
    logic rst_n_q, rst_n_d;
    logic scl_low_q, scl_low_d;
    logic sda_low_q, sda_low_d;
    tws_op_t op_q, op_d;
    logic [7:0] tx_q, tx_d;
    logic [7:0] rx_q, rx_d;
    logic [3:0] bit_q, bit_d;
    logic nack_q, nack_d;
    logic [31:0] cmd_q, cmd_d;
    logic sda_m, sda_s;
    logic done;
    logic wr_cmd;
    logic drive_bit;
    logic addr_ok;

    // Two-stage synchroniser for the data line
    always_ff @(posedge core_clk) begin
        sda_m <= link.sda_line;
        sda_s <= sda_m;
    end

    assign done = (timer_q == '0);
    assign addr_ok = (paddr[7:0] == CMD_OFS) || (paddr[7:0] == STATUS_OFS);
    assign wr_cmd = psel && penable && pwrite && (paddr[7:0] == CMD_OFS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // Data bits go out msb first; the ack slot carries the master's ack on reads
    always_comb begin
        if (bit_q < BIT_COUNT_BYTE) begin
            drive_bit = (op_q == OP_WRITE) && !tx_q[7]; // [R13]
        end else begin
            drive_bit = (op_q == OP_READ_ACK); // [R17]
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr[7:0] == CMD_OFS) begin
            prdata = cmd_q;
        end else if (paddr[7:0] == STATUS_OFS) begin
            prdata[STATUS_BUSY_BIT] = (state_q != H_IDLE);
            prdata[STATUS_NACK_BIT] = nack_q;
            prdata[STATUS_RX_LSB +: 8] = rx_q;
        end
    end

    always_comb begin
        state_d = state_q;
        timer_d = done ? timer_q : timer_q - 1'b1;
        rcnt_d = rcnt_q;
        rst_n_d = rst_n_q;
        scl_low_d = scl_low_q;
        sda_low_d = sda_low_q;
        op_d = op_q;
        tx_d = tx_q;
        rx_d = rx_q;
        bit_d = bit_q;
        nack_d = nack_q;
        cmd_d = wr_cmd ? pwdata : cmd_q;
        unique case (state_q)
            H_RST: begin
                if (rcnt_q == 32'h0000_0000) begin
                    rst_n_d = 1'b1; // [R2]
                    state_d = H_IDLE;
                end else begin
                    rcnt_d = rcnt_q - 1'b1;
                end
            end
            H_IDLE: begin
                if (wr_cmd) begin
                    op_d = tws_op_t'(pwdata[CMD_OP_LSB +: 3]);
                    tx_d = pwdata[CMD_DATA_LSB +: 8];
                    timer_d = LOW_T;
                    bit_d = 4'h0;
                    unique case (tws_op_t'(pwdata[CMD_OP_LSB +: 3]))
                        OP_START: begin
                            scl_low_d = 1'b1;
                            state_d = H_SA;
                        end
                        OP_STOP: begin
                            scl_low_d = 1'b1;
                            state_d = H_PA; // [R11]
                        end
                        OP_WRITE, OP_READ_ACK, OP_READ_NACK: begin
                            scl_low_d = 1'b1;
                            state_d = H_BLO;
                        end
                        default: begin
                            timer_d = timer_q;
                        end
                    endcase
                end
            end
            H_SA: begin
                if (timer_q == HALF_T) begin
                    sda_low_d = 1'b0;
                end
                if (done) begin
                    scl_low_d = 1'b0;
                    timer_d = HIGH_T;
                    state_d = H_SB;
                end
            end
            H_SB: begin
                if (done) begin
                    sda_low_d = 1'b1;
                    timer_d = HIGH_T;
                    state_d = H_SC;
                end
            end
            H_SC: begin
                if (done) begin
                    state_d = H_IDLE;
                end
            end
            H_BLO: begin
                // Data changes only in the middle of the low phase
                if (timer_q == HALF_T) begin
                    sda_low_d = drive_bit;
                end
                if (done) begin
                    scl_low_d = 1'b0;
                    timer_d = HIGH_T;
                    state_d = H_BHI;
                end
            end
            H_BHI: begin
                if (done) begin
                    scl_low_d = 1'b1;
                    if (bit_q < BIT_COUNT_BYTE) begin
                        rx_d = {rx_q[6:0], sda_s};
                        tx_d = {tx_q[6:0], 1'b0};
                        bit_d = bit_q + 1'b1;
                        timer_d = LOW_T;
                        state_d = H_BLO;
                    end else begin
                        nack_d = sda_s;
                        state_d = H_IDLE;
                    end
                end
            end
            H_PA: begin
                if (timer_q == HALF_T) begin
                    sda_low_d = 1'b1;
                end
                if (done) begin
                    scl_low_d = 1'b0;
                    timer_d = HIGH_T;
                    state_d = H_PB;
                end
            end
            H_PB: begin
                if (done) begin
                    sda_low_d = 1'b0;
                    timer_d = HIGH_T;
                    state_d = H_PC;
                end
            end
            H_PC: begin
                if (done) begin
                    state_d = H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= H_RST;
            timer_q <= '0;
            rcnt_q <= RESET_HOLD;
            rst_n_q <= 1'b0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            op_q <= OP_NONE;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            bit_q <= 4'h0;
            nack_q <= 1'b0;
            cmd_q <= CMD_RESET;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            rcnt_q <= rcnt_d;
            rst_n_q <= rst_n_d;
            scl_low_q <= scl_low_d;
            sda_low_q <= sda_low_d;
            op_q <= op_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            bit_q <= bit_d;
            nack_q <= nack_d;
            cmd_q <= cmd_d;
        end
    end

    assign link.host_scl_o = 1'b0;
    assign link.host_scl_oe = scl_low_q;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe = sda_low_q;
    assign link.device_reset_n = rst_n_q;
endmodule

// >>> logic/tws_link_if.sv
// Two-wire link between the bus master end and the register slave end.
// Both lines are open drain with pull-ups; the reset line is driven by the master.
`timescale 1ns/1ps
interface tws_link_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic device_reset_n;
    logic scl_line;
    logic sda_line;

    // Wired-AND with pull-up
    assign scl_line = host_scl_oe ? host_scl_o : 1'b1;
    assign sda_line = (host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o) ? 1'b0 : 1'b1;

    modport host (
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe,
        output device_reset_n,
        input scl_line,
        input sda_line
    );

    modport device (
        output dev_sda_o,
        output dev_sda_oe,
        input device_reset_n,
        input scl_line,
        input sda_line
    );
endinterface

// >>> logic/tws_pkg.sv
// Shared constants for the two-wire register slave and its bus master.
// Assumes a 250 MHz core clock on the master end and an 8 MHz link sampling
// clock on the slave end.
package tws_pkg;

    // Core clock of the master end
    localparam int CORE_CLK_PERIOD_NS = 4;

    // Serial clock shape: 400 kHz ceiling with minimum low and high periods
    localparam int SCL_MIN_PERIOD_NS = 2500;
    localparam int SCL_LOW_NS = 1300;
    localparam int SCL_HIGH_NS = 600;
    localparam int SCL_PERIOD_CYC = (SCL_MIN_PERIOD_NS + CORE_CLK_PERIOD_NS - 1)
                                    / CORE_CLK_PERIOD_NS;
    localparam int SCL_LOW_CYC = (SCL_LOW_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    localparam int SCL_HIGH_CYC = SCL_PERIOD_CYC - SCL_LOW_CYC;
    localparam int TIMER_W = 10;

    // Power-up reset hold of the slave
    localparam int RESET_HOLD_MS = 50;
    localparam int RESET_HOLD_CYC = RESET_HOLD_MS * 1000000 / CORE_CLK_PERIOD_NS;

    // APB register map of the master end
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_OP_LSB = 8;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_NACK_BIT = 1;
    localparam int STATUS_RX_LSB = 8;
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_START = 3'h1,
        OP_STOP = 3'h2,
        OP_WRITE = 3'h3,
        OP_READ_ACK = 3'h4,
        OP_READ_NACK = 3'h5
    } tws_op_t;

    // Register space of the slave
    localparam int REG_COUNT = 256;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [7:0] SCAN_CONTROL_OFS = 8'h62;
    localparam int MASTER_MODE_BIT = 3;
    localparam logic [7:0] PORT_CONFIG_OFS = 8'h8c;
    localparam int TUNER_BUS_EN_BIT = 0;
    localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;

endpackage

// >>> sim/tb.sv
// Bench: drives the master end over APB and talks to the slave end across the link.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/1ps
`define CMP(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
    import tws_pkg::*;
    logic core_clk = 0;
    logic link_clk = 0;
    logic sys_rst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [31:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata;
    logic [31:0] st;
    logic pready;
    logic [4:0] sa = 0;
    logic [6:0] a7;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] sc;
    logic mm;
    logic be;
    logic p0oe;
    logic drv_low = 0;
    logic obs_v = 0;
    logic [8:0] obs;
    logic [8:0] ev;
    logic [8:0] q[$];
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    tws_link_if link_if();
    tws_host #(.RESET_HOLD(100)) tws_host_inst(.core_clk(core_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(), .link(link_if));
    tws_device tws_device_inst(.link_clk(link_clk), .address_strap_pins(sa),
        .tuner_clk_drive_low(drv_low), .tuner_data_drive_low(drv_low), .tuner_data_in(),
        .tuner_master_mode(mm), .tuner_bus_enable(be), .scan_control(sc),
        .port_configuration(), .port_bit_zero_in(1'b1), .port_bit_zero_out(),
        .port_bit_zero_oe(p0oe), .port_bit_one_in(1'b1), .port_bit_one_out(),
        .port_bit_one_oe(), .link(link_if));
    tws_link_properties #(.RESET_HOLD(100)) tws_link_properties_inst(.core_clk(core_clk),
        .sys_rst(sys_rst), .link_clk(link_clk), .dev_sda_o(link_if.dev_sda_o),
        .dev_sda_oe(link_if.dev_sda_oe), .device_reset_n(link_if.device_reset_n),
        .scl_line(link_if.scl_line), .sda_line(link_if.sda_line));
    initial forever #2 core_clk = ~core_clk;
    initial begin
        #37;
        forever #62.5 link_clk = ~link_clk;
    end
    // Watchdog and result checker
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 98000) begin
            err_total++;
            conclude();
        end
        if (obs_v) begin
            ev = q.pop_front();
            `CMP(obs, ev)
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        st = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask
    task automatic cmd(input tws_op_t op, input logic [7:0] b);
        apb(1, CMD_OFS, {21'h0, op, b});
        do apb(0, STATUS_OFS, 32'h0); while (st[STATUS_BUSY_BIT] !== 1'b0);
    endtask
    task automatic put(input logic [8:0] g);
        obs <= g;
        obs_v <= 1;
        @(posedge core_clk);
        obs_v <= 0;
    endtask
    task automatic wb(input logic [7:0] b, input logic nk);
        q.push_back({nk, 8'h00});
        cmd(OP_WRITE, b);
        put({st[STATUS_NACK_BIT], 8'h00});
    endtask
    task automatic rb(input tws_op_t op, input logic [7:0] e);
        q.push_back({op == OP_READ_NACK, e});
        cmd(op, 8'h00);
        put({st[STATUS_NACK_BIT], st[15:8]});
    endtask
    initial begin
        void'($urandom(89313));
        sa <= 5'($urandom);
        d0 = 8'($urandom) | 8'h08;
        d1 = 8'($urandom) | 8'h01;
        repeat (10) @(posedge core_clk);
        sys_rst <= 0;
        a7 = {2'b00, sa};
        @(posedge core_clk);
        do apb(0, STATUS_OFS, 32'h0); while (st[STATUS_BUSY_BIT] !== 1'b0);
        repeat (5) @(posedge link_clk);
        @(posedge core_clk);
        // Tuner line request while the port is not enabled
        drv_low <= 1;
        cmd(OP_START, 8'h00);
        wb({a7, 1'b0}, 0);
        wb(SCAN_CONTROL_OFS, 0);
        wb(d0, 0);
        wb(d1, 0);
        cmd(OP_STOP, 8'h00);
        q.push_back({1'b0, d0});
        put({1'b0, sc});
        q.push_back(9'h100);
        put({mm, 6'h00, be, p0oe});
        $display("test 1 done");
        cmd(OP_START, 8'h00);
        wb({a7, 1'b0}, 0);
        wb(SCAN_CONTROL_OFS - 8'h01, 0);
        cmd(OP_START, 8'h00);
        wb({a7, 1'b1}, 0);
        rb(OP_READ_ACK, REG_RESET);
        rb(OP_READ_NACK, d0);
        cmd(OP_STOP, 8'h00);
        $display("test 2 done");
        cmd(OP_START, 8'h00);
        wb({a7, 1'b1}, 0);
        rb(OP_READ_NACK, REG_RESET);
        cmd(OP_STOP, 8'h00);
        $display("test 3 done");
        cmd(OP_START, 8'h00);
        wb({a7 ^ 7'h01, 1'b0}, 1);
        cmd(OP_START, 8'h00);
        wb({a7, 1'b0}, 0);
        wb(PORT_CONFIG_OFS, 0);
        wb(8'h01 << TUNER_BUS_EN_BIT, 0);
        cmd(OP_STOP, 8'h00);
        q.push_back(9'h103);
        put({mm, 6'h00, be, p0oe});
        $display("test 4 done");
        conclude();
    end
endmodule

// >>> sim/tws_link_properties.sv
// Checker for the two-wire link joining the bus master end and the slave end.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
module tws_link_properties #(
    parameter int RESET_HOLD = 20
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic device_reset_n,
    input wire logic scl_line,
    input wire logic sda_line
);
    import tws_pkg::*;
    int lo_q;
    int hi_q;
    int rst_q;
    // Lengths of the current clock low, clock high and slave reset phases
    always_ff @(posedge core_clk) begin
        lo_q <= (sys_rst || scl_line) ? 0 : lo_q + 1;
        // An idle bus after reset counts as a full clock high phase
        hi_q <= sys_rst ? SCL_HIGH_CYC : (!scl_line ? 0 : hi_q + 1);
        rst_q <= (sys_rst || device_reset_n) ? 0 : rst_q + 1;
    end
    sequence s_start;
        scl_line && $fell(sda_line);
    endsequence
    sequence s_stop;
        scl_line && $rose(sda_line);
    endsequence
    a_scl_low_len: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(scl_line) |-> lo_q >= SCL_LOW_CYC - 1) else $error("clock low too short");
    a_scl_high_len: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(scl_line) |-> hi_q >= SCL_HIGH_CYC - 1) else $error("clock high too short");
    a_reset_len: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(device_reset_n) |-> rst_q >= RESET_HOLD) else $error("slave reset too short");
    a_sda_change_low: assert property (@(posedge link_clk) disable iff (!device_reset_n)
        $changed(dev_sda_oe) |-> !scl_line) else $error("slave data moved with clock high");
    a_ack_bounded: assert property (@(posedge link_clk) disable iff (!device_reset_n)
        $rose(dev_sda_oe) |-> ##[1:250] !dev_sda_oe) else $error("slave holds data too long");
    a_quiet_start: assert property (@(posedge link_clk) disable iff (!device_reset_n)
        s_start |-> ##1 !dev_sda_oe [*8]) else $error("slave drives after start");
    a_quiet_stop: assert property (@(posedge link_clk) disable iff (!device_reset_n)
        s_stop |-> ##1 !dev_sda_oe [*8]) else $error("slave drives after stop");
    a_open_drain: assert property (@(posedge link_clk) disable iff (!device_reset_n)
        dev_sda_oe |-> !dev_sda_o) else $error("slave drives data high");
endmodule
